// >>> rtl/shp_pkg.sv
package shp_pkg;
    localparam int DW = 32;
    localparam int AW = 7;
    localparam int EVW = 8;
    // Device byte offsets on the host port
    localparam logic [7:0] RX_DATA_LO = 8'h00;
    localparam logic [7:0] RX_DATA_HI = 8'h1F;
    localparam logic [7:0] TX_DATA_LO = 8'h20;
    localparam logic [7:0] TX_DATA_HI = 8'h3F;
    localparam logic [7:0] IRQ_CFG    = 8'h54;
    localparam logic [7:0] INT_STS    = 8'h58;
    localparam logic [7:0] INT_EN     = 8'h5C;
    localparam logic [7:0] PMT_CTRL   = 8'h84;
    localparam logic [7:0] ENDIAN_CFG = 8'h98;
    // Interrupt configuration, power management and byte order fields
    localparam int IRQ_PP_BIT  = 0;
    localparam int IRQ_POL_BIT = 4;
    localparam int IRQ_EN_BIT  = 8;
    localparam int IRQ_OUT_BIT = 12;
    localparam int IRQ_INT_LSB = 24;
    localparam int PMT_SLEEP_BIT = 0;
    localparam int ENDIAN_BIG_BIT = 0;
    localparam logic [31:0] IRQ_CFG_RST = 32'h0000_0000;
    // Hold-off time base
    localparam int CLK_MHZ = 50;
    localparam int IRQ_UNIT_US = 10;
    localparam int IRQ_UNIT_CYC = IRQ_UNIT_US * CLK_MHZ;
    localparam int CLK_NS = 1000 / CLK_MHZ;
    // Host cycle timing
    localparam int STROBE_NS = 80;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    // Host controller AXI register offsets
    localparam logic [7:0] H_CMD   = 8'h00;
    localparam logic [7:0] H_WDATA = 8'h04;
    localparam logic [7:0] H_RDATA = 8'h08;
    localparam logic [7:0] H_STAT  = 8'h0C;
    localparam logic [7:0] H_ISTS  = 8'h10;
    localparam logic [7:0] H_IMASK = 8'h14;
    localparam int CMD_GO_BIT   = 0;
    localparam int CMD_WR_BIT   = 1;
    localparam int CMD_FSEL_BIT = 2;
    localparam int CMD_N16_BIT  = 3;
    localparam int CMD_POL_BIT  = 4;
    localparam int CMD_ADDR_LSB = 8;
    localparam logic [1:0] AXI_OKAY   = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage

// >>> rtl/shp_if.sv
// SRAM-like host port wires between controller and device
interface shp_if;
    logic [shp_pkg::AW-1:0] addr;
    logic                   cs_n;
    logic                   rd_n;
    logic                   wr_n;
    logic                   fifo_sel;
    logic [shp_pkg::DW-1:0] host_data_o;
    logic                   host_data_oe_n;
    logic [shp_pkg::DW-1:0] dev_data_o;
    logic                   dev_data_oe_n;
    logic                   dev_pulldown_en;
    logic                   irq_o;
    logic                   irq_oe_n;
    logic [shp_pkg::DW-1:0] data;
    logic                   irq_line;

    // Resolved data bus, weak pull-down when undriven
    always_comb
    begin
        if (!dev_data_oe_n)
            data = dev_data_o;
        else if (!host_data_oe_n)
            data = host_data_o;
        else
            data = '0;
    end
    // Interrupt line with pull-up when released
    assign irq_line = irq_oe_n ? 1'b1 : irq_o;

    modport host (output addr, cs_n, rd_n, wr_n, fifo_sel, host_data_o, host_data_oe_n,
                  input data, irq_line);
    modport dev (input addr, cs_n, rd_n, wr_n, fifo_sel, data,
                 output dev_data_o, dev_data_oe_n, dev_pulldown_en, irq_o, irq_oe_n);
endinterface

// >>> rtl/shp_irq_ctl.sv
// Interrupt pin driver with de-assertion hold-off
module shp_irq_ctl (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       pending,
    input  wire logic       enable,
    input  wire logic       active_high,
    input  wire logic       push_pull,
    input  wire logic [7:0] interval,
    output logic            asserted,
    output logic            irq_o,
    output logic            irq_oe_n
);
    logic [8:0] div_r, div_nxt;
    logic [7:0] hold_r, hold_nxt;
    logic       act_r, act_nxt;
    logic       o_r, o_nxt;
    logic       oe_n_r, oe_n_nxt;
    logic       tick;

    // Hold-off time base tick
    always_comb
    begin
        tick = (div_r == 9'h000);
        div_nxt = tick ? 9'(shp_pkg::IRQ_UNIT_CYC - 1) : div_r - 9'h001;
        act_nxt = act_r;
        hold_nxt = hold_r;
        if (act_r && !(enable && pending))
        begin
            act_nxt = 1'b0;
            hold_nxt = interval;
        end
        else if (!act_r && hold_r != 8'h00)
        begin
            if (tick)
                hold_nxt = hold_r - 8'h01;
        end
        else if (!act_r && enable && pending)
            act_nxt = 1'b1;
        // Pin levels from polarity and driver type
        if (push_pull)
        begin
            oe_n_nxt = 1'b0;
            o_nxt = act_nxt ? active_high : !active_high;
        end
        else
        begin
            oe_n_nxt = !act_nxt;
            o_nxt = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            {div_r, hold_r, act_r, o_r, oe_n_r} <= 20'h00001;
        else
            {div_r, hold_r, act_r, o_r, oe_n_r} <=
                {div_nxt, hold_nxt, act_nxt, o_nxt, oe_n_nxt};
    end

    assign asserted = act_r;
    assign irq_o = o_r;
    assign irq_oe_n = oe_n_r;
endmodule

// >>> rtl/shp_device.sv
// Device end of the SRAM-like host port
module shp_device (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    shp_if.dev                           hbus,
    input  wire logic                    bus_width_strap,
    input  wire logic [shp_pkg::EVW-1:0] events,
    input  wire logic [shp_pkg::DW-1:0]  rx_word,
    input  wire logic [shp_pkg::DW-1:0]  csr_rdata,
    output logic                         rx_pop,
    output logic                         tx_push,
    output logic [shp_pkg::DW-1:0]       tx_word,
    output logic                         csr_wr,
    output logic                         csr_rd,
    output logic [7:0]                   csr_addr,
    output logic [shp_pkg::DW-1:0]       csr_wdata,
    output logic                         low_power,
    output logic                         width32
);
    typedef enum logic [1:0] {SRC_RX, SRC_OWN, SRC_CSR} shp_src_type;

    logic                   w32_r, w32_nxt, seen_r, seen_nxt;
    logic                   rdp_r, rdp_nxt, wrp_r, wrp_nxt;
    logic [15:0]            hold_lo_r, hold_lo_nxt, hold_hi_r, hold_hi_nxt;
    logic                   fetch_r, fetch_nxt;
    shp_src_type            src_r, src_nxt;
    logic [7:0]             faddr_r, faddr_nxt;
    logic [31:0]            dout_r, dout_nxt;
    logic                   oe_n_r, oe_n_nxt;
    logic                   pd_r, pd_nxt;
    logic                   sleep_r, sleep_nxt, big_r, big_nxt;
    logic [31:0]            icfg_r, icfg_nxt;
    logic [shp_pkg::EVW-1:0] sts_r, sts_nxt, en_r, en_nxt;
    logic                   pop_r, pop_nxt, push_r, push_nxt;
    logic                   cwr_r, cwr_nxt, crd_r, crd_nxt;
    logic [31:0]            wword_r, wword_nxt;
    logic                   rd_q, wr_q, rd_go, wr_go;
    logic [7:0]             waddr;
    logic                   hi_half, in_rx, in_tx, is_own, is_csr;
    logic [31:0]            wjoin, wcommit, own_val, fword;
    logic                   commit;
    logic                   irq_act, irq_pin, irq_oe;

    function automatic logic [31:0] bswap(input logic [31:0] v);
        bswap = {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction

    // Qualified strobes and address decode
    always_comb
    begin
        rd_q = !hbus.cs_n && !hbus.rd_n;
        wr_q = !hbus.cs_n && !hbus.wr_n;
        rd_go = rd_q && !rdp_r && !sleep_r;
        wr_go = wr_q && !wrp_r && !sleep_r;
        waddr = {hbus.addr[6:1], 2'b00};
        hi_half = !w32_r && hbus.addr[0];
        in_rx = hbus.fifo_sel || (waddr <= shp_pkg::RX_DATA_HI);
        in_tx = hbus.fifo_sel
              || (waddr >= shp_pkg::TX_DATA_LO && waddr <= shp_pkg::TX_DATA_HI);
        is_own = !hbus.fifo_sel && (waddr == shp_pkg::IRQ_CFG || waddr == shp_pkg::INT_STS
               || waddr == shp_pkg::INT_EN || waddr == shp_pkg::PMT_CTRL
               || waddr == shp_pkg::ENDIAN_CFG);
        is_csr = !hbus.fifo_sel && !is_own && !in_rx && !in_tx;
    end

    // Write word assembly and byte order
    always_comb
    begin
        wjoin = w32_r ? hbus.data : {hbus.data[15:0], hold_lo_r};
        commit = wr_go && (w32_r || hi_half);
        wcommit = (big_r && !in_tx) ? bswap(wjoin) : wjoin;
    end

    // Own register read view and fetched word
    always_comb
    begin
        unique case (faddr_r)
            shp_pkg::IRQ_CFG:
                own_val = icfg_r | (32'(irq_act) << shp_pkg::IRQ_OUT_BIT);
            shp_pkg::INT_STS:    own_val = 32'(sts_r);
            shp_pkg::INT_EN:     own_val = 32'(en_r);
            shp_pkg::PMT_CTRL:   own_val = 32'(sleep_r) << shp_pkg::PMT_SLEEP_BIT;
            shp_pkg::ENDIAN_CFG: own_val = 32'(big_r) << shp_pkg::ENDIAN_BIG_BIT;
            default:             own_val = 32'h0000_0000;
        endcase
        unique case (src_r)
            SRC_RX:  fword = rx_word;
            SRC_OWN: fword = big_r ? bswap(own_val) : own_val;
            SRC_CSR: fword = big_r ? bswap(csr_rdata) : csr_rdata;
            default: fword = 32'h0000_0000;
        endcase
    end

    // Next state of the port
    always_comb
    begin
        w32_nxt = w32_r;
        seen_nxt = 1'b1;
        if (!seen_r)
            w32_nxt = bus_width_strap;
        pd_nxt = !w32_r;
        rdp_nxt = rd_q;
        wrp_nxt = wr_q;
        hold_lo_nxt = hold_lo_r;
        hold_hi_nxt = hold_hi_r;
        fetch_nxt = 1'b0;
        src_nxt = src_r;
        faddr_nxt = faddr_r;
        dout_nxt = dout_r;
        oe_n_nxt = !(rd_q && !sleep_r);
        sleep_nxt = sleep_r;
        big_nxt = big_r;
        icfg_nxt = icfg_r;
        en_nxt = en_r;
        sts_nxt = sts_r;
        pop_nxt = 1'b0;
        push_nxt = 1'b0;
        cwr_nxt = 1'b0;
        crd_nxt = 1'b0;
        wword_nxt = wword_r;
        // Wakeup on a selected write while asleep
        if (sleep_r && wr_q && !wrp_r)
            sleep_nxt = 1'b0;
        // Writes
        if (wr_go && !w32_r && !hi_half)
            hold_lo_nxt = hbus.data[15:0];
        if (commit)
        begin
            if (in_tx)
            begin
                push_nxt = 1'b1;
                wword_nxt = wcommit;
            end
            else if (is_csr)
            begin
                cwr_nxt = 1'b1;
                faddr_nxt = waddr;
                wword_nxt = wcommit;
            end
            else if (is_own)
            begin
                unique case (waddr)
                    shp_pkg::IRQ_CFG:    icfg_nxt = wcommit;
                    shp_pkg::INT_STS:    sts_nxt = sts_r & ~wcommit[shp_pkg::EVW-1:0];
                    shp_pkg::INT_EN:     en_nxt = wcommit[shp_pkg::EVW-1:0];
                    shp_pkg::PMT_CTRL:   sleep_nxt = wcommit[shp_pkg::PMT_SLEEP_BIT];
                    shp_pkg::ENDIAN_CFG: big_nxt = wcommit[shp_pkg::ENDIAN_BIG_BIT];
                    default:             sleep_nxt = sleep_r;
                endcase
            end
        end
        sts_nxt = sts_nxt | events; // set wins over clear
        // Reads: start fetch, or serve upper halfword
        if (rd_go && hi_half)
            dout_nxt = {16'h0000, hold_hi_r};
        else if (rd_go)
        begin
            fetch_nxt = 1'b1;
            faddr_nxt = waddr;
            if (in_rx)
            begin
                src_nxt = SRC_RX;
                pop_nxt = 1'b1;
            end
            else if (is_own)
                src_nxt = SRC_OWN;
            else
            begin
                src_nxt = SRC_CSR;
                crd_nxt = !in_tx;
            end
        end
        if (fetch_r)
        begin
            hold_hi_nxt = fword[31:16];
            dout_nxt = w32_r ? fword : {16'h0000, fword[15:0]};
        end
    end

    // Port registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {w32_r, seen_r, pd_r, rdp_r, wrp_r, fetch_r, oe_n_r} <= 7'h41;
            {sleep_r, big_r, pop_r, push_r, cwr_r, crd_r} <= 6'h00;
            {hold_lo_r, hold_hi_r, faddr_r, dout_r, wword_r} <= 104'h0;
            src_r <= SRC_RX;
            icfg_r <= shp_pkg::IRQ_CFG_RST;
            {en_r, sts_r} <= 16'h0000;
        end
        else
        begin
            {w32_r, seen_r, pd_r, rdp_r, wrp_r, fetch_r, oe_n_r} <=
                {w32_nxt, seen_nxt, pd_nxt, rdp_nxt, wrp_nxt, fetch_nxt, oe_n_nxt};
            {sleep_r, big_r, pop_r, push_r, cwr_r, crd_r} <=
                {sleep_nxt, big_nxt, pop_nxt, push_nxt, cwr_nxt, crd_nxt};
            {hold_lo_r, hold_hi_r, faddr_r, dout_r, wword_r} <=
                {hold_lo_nxt, hold_hi_nxt, faddr_nxt, dout_nxt, wword_nxt};
            src_r <= src_nxt;
            icfg_r <= icfg_nxt;
            {en_r, sts_r} <= {en_nxt, sts_nxt};
        end
    end

    // Interrupt pin
    shp_irq_ctl u_irq (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .pending     (|(sts_r & en_r)),
        .enable      (icfg_r[shp_pkg::IRQ_EN_BIT]),
        .active_high (icfg_r[shp_pkg::IRQ_POL_BIT]),
        .push_pull   (icfg_r[shp_pkg::IRQ_PP_BIT]),
        .interval    (icfg_r[shp_pkg::IRQ_INT_LSB +: 8]),
        .asserted    (irq_act),
        .irq_o       (irq_pin),
        .irq_oe_n    (irq_oe)
    );

    assign hbus.irq_o = irq_pin;
    assign hbus.irq_oe_n = irq_oe;
    assign hbus.dev_data_o = dout_r;
    assign hbus.dev_data_oe_n = oe_n_r;
    assign hbus.dev_pulldown_en = pd_r;
    assign rx_pop = pop_r;
    assign tx_push = push_r;
    assign tx_word = wword_r;
    assign csr_wr = cwr_r;
    assign csr_rd = crd_r;
    assign csr_addr = faddr_r;
    assign csr_wdata = wword_r;
    assign low_power = sleep_r;
    assign width32 = w32_r;
endmodule

// >>> rtl/shp_host.sv
// Host end: AXI4-Lite commanded SRAM-like bus master
module shp_host (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    shp_if.host              hbus,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             irq
);
    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} shp_hst_state_type;

    shp_hst_state_type st_r, st_nxt;
    logic [2:0]  cnt_r, cnt_nxt;
    logic [31:0] cmd_r, cmd_nxt, wd_r, wd_nxt, rd_r, rd_nxt;
    logic [1:0]  ists_r, ists_nxt, imask_r, imask_nxt;
    logic        irq_r, irq_nxt, lvl_r, lvl_nxt;
    logic        awg_r, awg_nxt, wg_r, wg_nxt;
    logic [7:0]  awa_r, awa_nxt;
    logic [31:0] axw_r, axw_nxt, rdat_r, rdat_nxt;
    logic        bv_r, bv_nxt, rv_r, rv_nxt;
    logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
    logic        do_wr, done, lvl;
    logic [31:0] rval;

    // AXI slave, command registers, bus cycle
    always_comb
    begin
        {st_nxt, cnt_nxt, cmd_nxt, wd_nxt, rd_nxt} = {st_r, cnt_r, cmd_r, wd_r, rd_r};
        {ists_nxt, imask_nxt, awg_nxt, wg_nxt} = {ists_r, imask_r, awg_r, wg_r};
        {awa_nxt, axw_nxt, rdat_nxt, bv_nxt, rv_nxt} = {awa_r, axw_r, rdat_r, bv_r, rv_r};
        br_nxt = br_r;
        rr_nxt = rr_r;
        done = 1'b0;
        if (s_axi_awvalid && !awg_r && !bv_r)
        begin
            awg_nxt = 1'b1;
            awa_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !wg_r && !bv_r)
        begin
            wg_nxt = 1'b1;
            axw_nxt = s_axi_wdata;
        end
        do_wr = awg_r && wg_r && !bv_r;
        if (do_wr)
        begin
            {awg_nxt, wg_nxt, bv_nxt} = 3'b001;
            br_nxt = shp_pkg::AXI_OKAY;
            unique case (awa_r)
                shp_pkg::H_CMD:
                    if (st_r == ST_IDLE)
                    begin
                        cmd_nxt = axw_r;
                        if (axw_r[shp_pkg::CMD_GO_BIT])
                            st_nxt = ST_SETUP;
                    end
                shp_pkg::H_WDATA: wd_nxt = axw_r;
                shp_pkg::H_ISTS:  ists_nxt = ists_r & ~axw_r[1:0];
                shp_pkg::H_IMASK: imask_nxt = axw_r[1:0];
                default:          br_nxt = shp_pkg::AXI_SLVERR;
            endcase
        end
        if (bv_r && s_axi_bready)
            bv_nxt = 1'b0;
        unique case (s_axi_araddr)
            shp_pkg::H_CMD:   rval = cmd_r;
            shp_pkg::H_WDATA: rval = wd_r;
            shp_pkg::H_RDATA: rval = rd_r;
            shp_pkg::H_STAT:  rval = {30'h0, lvl_r, st_r != ST_IDLE};
            shp_pkg::H_ISTS:  rval = {30'h0, ists_r};
            shp_pkg::H_IMASK: rval = {30'h0, imask_r};
            default:          rval = 32'h0000_0000;
        endcase
        if (s_axi_arvalid && !rv_r)
        begin
            rv_nxt = 1'b1;
            rdat_nxt = rval;
            rr_nxt = (s_axi_araddr <= shp_pkg::H_IMASK && s_axi_araddr[1:0] == 2'b00)
                   ? shp_pkg::AXI_OKAY : shp_pkg::AXI_SLVERR;
        end
        else if (rv_r && s_axi_rready)
            rv_nxt = 1'b0;
        // Bus cycle sequencer
        unique case (st_r)
            ST_IDLE:  cnt_nxt = 3'h0;
            ST_SETUP: st_nxt = ST_STROBE;
            ST_STROBE:
                if (cnt_r == 3'(shp_pkg::STROBE_CYC - 1))
                begin
                    st_nxt = ST_HOLD;
                    if (!cmd_r[shp_pkg::CMD_WR_BIT])
                        rd_nxt = cmd_r[shp_pkg::CMD_N16_BIT] ? {16'h0, hbus.data[15:0]}
                               : hbus.data;
                end
                else
                    cnt_nxt = cnt_r + 3'h1;
            ST_HOLD:
            begin
                st_nxt = ST_IDLE;
                done = 1'b1;
            end
        endcase
        lvl = (hbus.irq_line == cmd_r[shp_pkg::CMD_POL_BIT]);
        lvl_nxt = lvl;
        ists_nxt = ists_nxt | {lvl && !lvl_r, done}; // set wins over clear
        irq_nxt = |(ists_nxt & imask_nxt);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {st_r, cnt_r, cmd_r, wd_r, rd_r} <= {ST_IDLE, 3'h0, 96'h0};
            {ists_r, imask_r, irq_r, lvl_r, awg_r, wg_r} <= 8'h00;
            {awa_r, axw_r, rdat_r, bv_r, rv_r, br_r, rr_r} <= 78'h0;
        end
        else
        begin
            {st_r, cnt_r, cmd_r, wd_r, rd_r} <= {st_nxt, cnt_nxt, cmd_nxt, wd_nxt, rd_nxt};
            {ists_r, imask_r, irq_r, lvl_r} <= {ists_nxt, imask_nxt, irq_nxt, lvl_nxt};
            {awg_r, wg_r, awa_r, axw_r} <= {awg_nxt, wg_nxt, awa_nxt, axw_nxt};
            {rdat_r, bv_r, rv_r, br_r, rr_r} <= {rdat_nxt, bv_nxt, rv_nxt, br_nxt, rr_nxt};
        end
    end

    // Pin drive straight from registers
    logic [6:0]  pa_r;
    logic        pcs_r, prd_r, pwr_r, pfs_r, poe_r;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            {pa_r, pcs_r, prd_r, pwr_r, pfs_r, poe_r} <= 12'hFBF;
        else
        begin
            pa_r <= cmd_r[shp_pkg::CMD_ADDR_LSB +: 7];
            pfs_r <= cmd_r[shp_pkg::CMD_FSEL_BIT];
            pcs_r <= !(st_nxt != ST_IDLE);
            prd_r <= !(st_nxt == ST_STROBE && !cmd_r[shp_pkg::CMD_WR_BIT]);
            pwr_r <= !(st_nxt == ST_STROBE && cmd_r[shp_pkg::CMD_WR_BIT]);
            poe_r <= !(st_nxt != ST_IDLE && cmd_r[shp_pkg::CMD_WR_BIT]);
        end
    end

    assign hbus.addr = pa_r;
    assign hbus.cs_n = pcs_r;
    assign hbus.rd_n = prd_r;
    assign hbus.wr_n = pwr_r;
    assign hbus.fifo_sel = pfs_r;
    assign hbus.host_data_o = wd_r;
    assign hbus.host_data_oe_n = poe_r;
    assign s_axi_awready = !awg_r && !bv_r;
    assign s_axi_wready = !wg_r && !bv_r;
    assign s_axi_bvalid = bv_r;
    assign s_axi_bresp = br_r;
    assign s_axi_arready = !rv_r;
    assign s_axi_rvalid = rv_r;
    assign s_axi_rdata = rdat_r;
    assign s_axi_rresp = rr_r;
    assign irq = irq_r;
endmodule

// >>> verification/shp_chk.sv
module shp_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic host_data_oe_n,
    input wire logic dev_data_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rq;
    // Qualified read strobe
    assign rq = !cs_n && !rd_n;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    rd_drive_a: assert property (!dev_data_oe_n |-> $past(rq))
        else $error("data driven outside a read");
    rd_answer_a: assert property (rq && !$past(rq) |=> !dev_data_oe_n)
        else $error("read not answered");
    rd_hold_a: assert property (!dev_data_oe_n && rq |=> !dev_data_oe_n)
        else $error("drive dropped mid read");
    rd_release_a: assert property ($rose(rd_n) |=> dev_data_oe_n)
        else $error("drive not released");
    cs_gate_a: assert property (cs_n |=> dev_data_oe_n)
        else $error("drive without chip select");
    no_fight_a: assert property (!(!dev_data_oe_n && !host_data_oe_n))
        else $error("both ends drive data");
    strobe_len_a: assert property (rq && !$past(rq) |-> rq[*4])
        else $error("read strobe too short");
    wr_cs_a: assert property (!wr_n |-> !cs_n)
        else $error("write strobe without select");
    cover property (rq && !$past(rq));
    cover property (!wr_n && !cs_n);
    cover property ($rose(rd_n));
endmodule

// >>> verification/tb_shp.sv
module tb_shp;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] RXW = 32'hA5C3_0F96;
    localparam logic [31:0] CSV = 32'h0BAD_F00D;
    logic        aclk = 1'b0, aresetn = 1'b0, strap = 1'b1;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq, tx_push, csr_wr, low_power, width32;
    logic [1:0]  bresp, rresp;
    logic [7:0]  events = 8'h00, awaddr = 8'h00, araddr = 8'h00, csr_addr;
    logic [31:0] wdata = 32'h0, rdata, tx_word, csr_wdata, tx_seen, csr_seen, rv;
    int          err_total = 0, checks = 0;
    shp_if u_shp_if ();
    shp_device u_shp_device (.aclk(aclk), .aresetn(aresetn), .hbus(u_shp_if),
        .bus_width_strap(strap), .events(events), .rx_word(RXW), .csr_rdata(CSV), .rx_pop(),
        .tx_push(tx_push), .tx_word(tx_word), .csr_wr(csr_wr), .csr_rd(), .csr_addr(csr_addr),
        .csr_wdata(csr_wdata), .low_power(low_power), .width32(width32));
    shp_host u_shp_host (.aclk(aclk), .aresetn(aresetn), .hbus(u_shp_if), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
    shp_chk u_shp_chk (.aclk(aclk), .aresetn(aresetn), .cs_n(u_shp_if.cs_n),
        .rd_n(u_shp_if.rd_n), .wr_n(u_shp_if.wr_n), .host_data_oe_n(u_shp_if.host_data_oe_n),
        .dev_data_oe_n(u_shp_if.dev_data_oe_n));
    always #10 aclk = ~aclk;
    // Catch words leaving the port
    always @(posedge aclk) if (tx_push) tx_seen <= tx_word;
    always @(posedge aclk) if (csr_wr) csr_seen <= csr_wdata;
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic tmo();
        err_total++;
        summarize();
    endtask
    // AXI write, both channels offered together
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        bit aw, w, dn;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        for (int n = 0; n < 100 && !dn; n++)
        begin
            @(negedge aclk);
            aw = awready;
            w = wready;
            dn = bvalid;
            @(posedge aclk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (!dn) tmo();
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d);
        bit ar, dn;
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        for (int n = 0; n < 100 && !dn; n++)
        begin
            @(negedge aclk);
            ar = arready;
            dn = rvalid;
            d = rdata;
            @(posedge aclk);
            if (ar) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (!dn) tmo();
    endtask
    // Port cycle through the controller, then poll busy
    task automatic op(input logic [7:0] ba, input logic [7:0] f, input logic [31:0] d);
        axw(shp_pkg::H_WDATA, d);
        axw(shp_pkg::H_CMD, {17'h0, ba[7:1], f | 8'h11});
        rv = 32'h1;
        for (int n = 0; n < 50 && rv[0]; n++) axr(shp_pkg::H_STAT, rv);
        if (rv[0]) tmo();
    endtask
    task automatic rdx(input logic [7:0] ba, input logic [7:0] f, input logic [31:0] e,
        input logic [31:0] m, input string s);
        op(ba, f, 32'h0);
        axr(shp_pkg::H_RDATA, rv);
        chk(s, e, rv & m);
    endtask
    task automatic rst(input logic s);
        aresetn <= 1'b0;
        strap <= s;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
    endtask
    task automatic pulse();
        @(posedge aclk);
        events <= 8'h01;
        @(posedge aclk);
        events <= 8'h00;
    endtask
    // Main sequence
    initial
    begin
        rst(1'b1);
        chk("width32", 32'h1, 32'(width32));
        chk("pulldown", 32'h0, 32'(u_shp_if.dev_pulldown_en));
        op(8'h20, 8'h02, 32'h1234_5678);
        chk("tx32", 32'h1234_5678, tx_seen);
        rdx(8'h00, 8'h00, RXW, '1, "rx32");
        op(8'hFE, 8'h06, 32'hCAFE_0001);
        chk("fsel tx", 32'hCAFE_0001, tx_seen);
        rdx(8'h54, 8'h04, RXW, '1, "fsel rx");
        rdx(8'h40, 8'h00, CSV, '1, "csr rd");
        op(shp_pkg::ENDIAN_CFG, 8'h02, 32'h1);
        op(8'h40, 8'h02, 32'h1122_3344);
        chk("csr big", 32'h4433_2211, csr_seen);
        rdx(8'h40, 8'h00, 32'h0DF0_AD0B, '1, "csr big rd");
        op(shp_pkg::ENDIAN_CFG, 8'h02, 32'h0);
        $display("test 32-bit paths done");
        op(shp_pkg::IRQ_CFG, 8'h02, 32'h0200_0111);
        op(shp_pkg::INT_EN, 8'h02, 32'h1);
        axw(shp_pkg::H_ISTS, 32'h2);
        axw(shp_pkg::H_IMASK, 32'h2);
        pulse();
        for (int n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge aclk);
        chk("irq up", 32'h1, 32'(irq));
        op(shp_pkg::INT_STS, 8'h02, 32'h1);
        axw(shp_pkg::H_ISTS, 32'h2);
        pulse();
        repeat (100) @(posedge aclk);
        chk("irq holdoff", 32'h0, 32'(irq));
        for (int n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge aclk);
        chk("irq again", 32'h1, 32'(irq));
        axw(shp_pkg::H_IMASK, 32'h0);
        repeat (2) @(posedge aclk);
        chk("irq masked", 32'h0, 32'(irq));
        axw(shp_pkg::H_IMASK, 32'h2);
        repeat (2) @(posedge aclk);
        chk("irq unmask", 32'h1, 32'(irq));
        $display("test interrupt done");
        op(shp_pkg::PMT_CTRL, 8'h02, 32'h1);
        chk("sleep", 32'h1, 32'(low_power));
        op(8'h20, 8'h02, 32'h5555_AAAA);
        chk("wake", 32'h0, 32'(low_power));
        chk("wake dropped", 32'hCAFE_0001, tx_seen);
        rst(1'b0);
        chk("width16", 32'h0, 32'(width32));
        chk("pulldown16", 32'h1, 32'(u_shp_if.dev_pulldown_en));
        op(8'h20, 8'h0A, 32'h0000_5678);
        op(8'h22, 8'h0A, 32'h0000_1234);
        chk("tx16", 32'h1234_5678, tx_seen);
        rdx(8'h00, 8'h08, {16'h0, RXW[15:0]}, 32'hFFFF, "rx16 lo");
        rdx(8'h02, 8'h08, {16'h0, RXW[31:16]}, 32'hFFFF, "rx16 hi");
        $display("test 16-bit and wake done");
        summarize();
    end
endmodule
